// file: rtl/clps_cable_loss_pulse_regs.sv
// Function
// - The six-bit cable attenuation figure, good to one decibel, is readable but never writable.
// - The attenuation figure follows the receive equalizer setting and sits at address 00111.
// - Bit 5 of that register is the MSB, bit 0 the LSB, and bits 7 and 6 read as zero.
// - In arbitrary pulse mode a pulse is eight consecutive segments filling one master period.
// - The segment amplitudes shape the output only while arbitrary pulse mode is selected.
// - Each segment register holds a seven-bit amplitude code in its low seven bits.
// - The amplitude code is signed magnitude, bit 6 the sign and bits 5 to 0 the magnitude.
// - The register at address 01000 gives the amplitude of the first segment.
// - The register at address 01001 gives the amplitude of the second segment.
// - Reset clears the attenuation figure and both segment registers wholly to zero.
module clps_cable_loss_pulse_regs #(
   parameter int SEG_CYCLES = clps_pkg::SEG_CYCLES_DEFAULT
) (
   input wire logic I_CLOCK, // 200 MHz system clock
   input wire logic I_SRST, // Synchronous reset, active high
   input wire clps_pkg::clps_req_s I_REQ, // Host register request
   output logic [7:0] O_RDATA, // Read data, valid with O_RVALID
   output logic O_RVALID, // Read answer pulse
   input wire logic [5:0] I_EQ_SETTING, // Receive equalizer setting
   input wire logic I_ARB_MODE, // Arbitrary pulse mode selected
   output logic [2:0] O_SEG_INDEX, // Current time segment
   output logic O_SEG_START, // Pulse period start pulse
   output logic O_ARB_ACTIVE, // Sequencer running
   output logic O_AMP_VALID, // Amplitude below comes from this block
   output clps_pkg::clps_amp_s O_AMP // Segment amplitude
);

   // Refuse, at elaboration, a segment length the 16-bit divider cannot count
   if (SEG_CYCLES < 1 || SEG_CYCLES > 65535) begin
      $error("SEG_CYCLES out of range");
   end

   // Last divider count of a segment
   localparam logic [15:0] SEG_LAST_COUNT = 16'(SEG_CYCLES - 1);

   // Host-visible register storage
   logic [7:0] cable_attenuation_status;
   logic [7:0] pulse_segment_one_amplitude;
   logic [7:0] pulse_segment_two_amplitude;

   // Sequencer state and segment divider
   clps_pkg::clps_state_e state;
   clps_pkg::clps_state_e next_state;
   logic [15:0] div_count;
   logic seg_tick;
   logic [2:0] seg_index;
   logic [2:0] next_seg_index;

   // Next values of the registered pulse outputs
   logic next_seg_start;
   logic next_amp_valid;
   clps_pkg::clps_amp_s next_amp;

   // Address match, shared by read and write decode
   function automatic logic addr_hit(input logic [4:0] a, input logic [4:0] target);
      addr_hit = (a == target);
   endfunction

   // Low seven bits as signed magnitude; bit 7 dropped on purpose
   function automatic clps_pkg::clps_amp_s to_amp(input logic [7:0] r);
      clps_pkg::clps_amp_s amp;
      amp.sign = r[clps_pkg::AMP_SIGN_BIT];
      amp.magnitude = r[clps_pkg::AMP_MAG_MSB:clps_pkg::AMP_MAG_LSB];
      to_amp = amp;
   endfunction

   // Attenuation figure tracks the equalizer every cycle; upper bits held at zero
   // No read latch, so a read answer shows the setting of two cycles before
   always_ff @(posedge I_CLOCK) begin
      if (I_SRST) begin
         cable_attenuation_status <= clps_pkg::RST_CABLE_ATTENUATION_STATUS;
      end else begin
         cable_attenuation_status <= {2'h0, I_EQ_SETTING};
      end
   end

   // Segment one register, all eight bits stored
   // Writes to any other address leave it untouched
   always_ff @(posedge I_CLOCK) begin
      if (I_SRST) begin
         pulse_segment_one_amplitude <= clps_pkg::RST_PULSE_SEGMENT_AMPLITUDE;
      end else if (I_REQ.wr && addr_hit(I_REQ.addr,
                   clps_pkg::ADDR_PULSE_SEGMENT_ONE_AMPLITUDE)) begin
         pulse_segment_one_amplitude <= I_REQ.wdata;
      end
   end

   // Segment two register, all eight bits stored
   always_ff @(posedge I_CLOCK) begin
      if (I_SRST) begin
         pulse_segment_two_amplitude <= clps_pkg::RST_PULSE_SEGMENT_AMPLITUDE;
      end else if (I_REQ.wr && addr_hit(I_REQ.addr,
                   clps_pkg::ADDR_PULSE_SEGMENT_TWO_AMPLITUDE)) begin
         pulse_segment_two_amplitude <= I_REQ.wdata;
      end
   end

   // Read port; writes to the status address fall through unused
   // A read and a write to one register in the same cycle return the old value
   always_ff @(posedge I_CLOCK) begin
      if (I_SRST) begin
         O_RDATA <= clps_pkg::RDATA_UNMAPPED;
         O_RVALID <= 1'b0;
      end else begin
         O_RVALID <= I_REQ.rd;
         if (!I_REQ.rd) begin
            O_RDATA <= O_RDATA;
         end else if (addr_hit(I_REQ.addr, clps_pkg::ADDR_CABLE_ATTENUATION_STATUS)) begin
            O_RDATA <= cable_attenuation_status;
         end else if (addr_hit(I_REQ.addr, clps_pkg::ADDR_PULSE_SEGMENT_ONE_AMPLITUDE)) begin
            O_RDATA <= pulse_segment_one_amplitude;
         end else if (addr_hit(I_REQ.addr, clps_pkg::ADDR_PULSE_SEGMENT_TWO_AMPLITUDE)) begin
            O_RDATA <= pulse_segment_two_amplitude;
         end else begin
            O_RDATA <= clps_pkg::RDATA_UNMAPPED; // Unmapped reads as zero
         end
      end
   end

   // Sequencer runs only in arbitrary pulse mode
   // Leaving the mode drops every pulse output to zero at the next edge
   always_comb begin
      next_state = state;
      case (state)
         clps_pkg::CLPS_IDLE: begin
            if (I_ARB_MODE) begin
               next_state = clps_pkg::CLPS_RUN;
            end
         end
         clps_pkg::CLPS_RUN: begin
            if (!I_ARB_MODE) begin
               next_state = clps_pkg::CLPS_IDLE;
            end
         end
         default: begin
            next_state = clps_pkg::CLPS_IDLE;
         end
      endcase
   end

   // State register; reset leaves the sequencer idle
   always_ff @(posedge I_CLOCK) begin
      if (I_SRST) begin
         state <= clps_pkg::CLPS_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Segment divider; restarts whenever the mode is entered
   assign seg_tick = (state == clps_pkg::CLPS_RUN) && (div_count == SEG_LAST_COUNT);

   // Divider counts one segment, then wraps on the tick
   always_ff @(posedge I_CLOCK) begin
      if (I_SRST || state != clps_pkg::CLPS_RUN) begin
         div_count <= 16'h0000;
      end else if (seg_tick) begin
         div_count <= 16'h0000;
      end else begin
         div_count <= div_count + 16'h0001;
      end
   end

   // Eight segments per period, wrapping after the last
   always_comb begin
      next_seg_index = seg_index;
      if (next_state != clps_pkg::CLPS_RUN) begin
         next_seg_index = clps_pkg::SEG_INDEX_FIRST;
      end else if (seg_tick) begin
         next_seg_index = (seg_index == clps_pkg::SEG_INDEX_LAST) ?
                          clps_pkg::SEG_INDEX_FIRST : seg_index + 3'h1;
      end
   end

   // Segment index register
   always_ff @(posedge I_CLOCK) begin
      if (I_SRST) begin
         seg_index <= clps_pkg::SEG_INDEX_FIRST;
      end else begin
         seg_index <= next_seg_index;
      end
   end

   // Period start on entry into the mode and on each wrap
   assign next_seg_start = (next_state == clps_pkg::CLPS_RUN) &&
                           ((state != clps_pkg::CLPS_RUN) ||
                            (seg_tick && seg_index == clps_pkg::SEG_INDEX_LAST));

   // Amplitude for the segments this block owns; others come from elsewhere
   // Reserved bit 7 is cut off in the conversion and never shapes the pulse
   always_comb begin
      next_amp = '0;
      next_amp_valid = 1'b0;
      if (next_state == clps_pkg::CLPS_RUN) begin
         if (next_seg_index == clps_pkg::SEG_INDEX_FIRST) begin
            next_amp = to_amp(pulse_segment_one_amplitude);
            next_amp_valid = 1'b1;
         end else if (next_seg_index == clps_pkg::SEG_INDEX_SECOND) begin
            next_amp = to_amp(pulse_segment_two_amplitude);
            next_amp_valid = 1'b1;
         end
      end
   end

   // Registered pulse outputs, aligned with the segment index
   // Next values are registered here so no output carries a combinational path
   always_ff @(posedge I_CLOCK) begin
      if (I_SRST) begin
         O_SEG_INDEX <= clps_pkg::SEG_INDEX_FIRST;
         O_SEG_START <= 1'b0;
         O_ARB_ACTIVE <= 1'b0;
         O_AMP_VALID <= 1'b0;
         O_AMP <= '0;
      end else begin
         O_SEG_INDEX <= next_seg_index;
         O_SEG_START <= next_seg_start;
         O_ARB_ACTIVE <= (next_state == clps_pkg::CLPS_RUN);
         O_AMP_VALID <= next_amp_valid;
         O_AMP <= next_amp;
      end
   end

endmodule

// file: rtl/clps_pkg.sv
package clps_pkg;
   // Register addresses on the 5-bit host register port
   localparam logic [4:0] ADDR_CABLE_ATTENUATION_STATUS = 5'h07;
   localparam logic [4:0] ADDR_PULSE_SEGMENT_ONE_AMPLITUDE = 5'h08;
   localparam logic [4:0] ADDR_PULSE_SEGMENT_TWO_AMPLITUDE = 5'h09;

   // Reset values
   localparam logic [7:0] RST_CABLE_ATTENUATION_STATUS = 8'h00;
   localparam logic [7:0] RST_PULSE_SEGMENT_AMPLITUDE = 8'h00;
   localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

   // Field positions
   localparam int CABLE_ATTENUATION_MSB = 5;
   localparam int CABLE_ATTENUATION_LSB = 0;
   localparam int AMP_SIGN_BIT = 6;
   localparam int AMP_MAG_MSB = 5;
   localparam int AMP_MAG_LSB = 0;
   localparam int SEG_RESERVED_BIT = 7;

   // Pulse timing
   localparam int SEGMENTS_PER_PERIOD = 8;
   localparam int SEG_CYCLES_DEFAULT = 16;
   localparam logic [2:0] SEG_INDEX_FIRST = 3'h0;
   localparam logic [2:0] SEG_INDEX_SECOND = 3'h1;
   localparam logic [2:0] SEG_INDEX_LAST = 3'h7;

   // Signed-magnitude amplitude of one segment
   typedef struct packed {
      logic sign;
      logic [5:0] magnitude;
   } clps_amp_s;

   // Host register request
   typedef struct packed {
      logic [4:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } clps_req_s;

   // Pulse sequencer states
   typedef enum logic [1:0] {
      CLPS_IDLE = 2'b00,
      CLPS_RUN = 2'b01
   } clps_state_e;
endpackage

// file: tb/clps_cable_loss_pulse_regs_sva.sv
module clps_cable_loss_pulse_regs_sva #(
   parameter int SEG_CYCLES = 16
) (
   input wire logic I_CLOCK, // Clock
   input wire logic I_SRST, // Reset
   input wire clps_pkg::clps_req_s I_REQ, // Request
   input wire logic [7:0] O_RDATA, // Read data
   input wire logic O_RVALID, // Answer
   input wire logic [5:0] I_EQ_SETTING, // Equalizer
   input wire logic I_ARB_MODE, // Pulse mode
   input wire logic [2:0] O_SEG_INDEX, // Segment
   input wire logic O_SEG_START, // Start
   input wire logic O_ARB_ACTIVE, // Running
   input wire logic O_AMP_VALID, // Amp valid
   input wire clps_pkg::clps_amp_s O_AMP // Amplitude
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge I_CLOCK); endclocking
   default disable iff (I_SRST);
   logic [2:0] pidx;
   int run;
   // Segment run length, zero while idle so an entry counts from one
   always_ff @(posedge I_CLOCK) begin
      pidx <= O_SEG_INDEX;
      run <= (I_SRST || !O_ARB_ACTIVE) ? 0 : (O_SEG_INDEX != pidx) ? 1 : run + 1;
   end
   rd_answer_a: assert property (O_RVALID == $past(I_REQ.rd))
      else $error("answer timing");
   status_read_a: assert property (I_REQ.rd && I_REQ.addr == 5'h07
      |=> O_RDATA == {2'b00, $past(I_EQ_SETTING, 2)}) else $error("attenuation read");
   seg_readback_a: assert property (I_REQ.wr && !I_REQ.rd ##1 I_REQ.rd && !I_REQ.wr
      && I_REQ.addr == $past(I_REQ.addr) && I_REQ.addr inside {5'h08, 5'h09}
      |=> O_RDATA == $past(I_REQ.wdata, 2)) else $error("segment readback");
   mode_off_a: assert property (!I_ARB_MODE |=> !O_ARB_ACTIVE && !O_AMP_VALID
      && O_AMP == 7'h00) else $error("output while off");
   seg_dwell_a: assert property (O_ARB_ACTIVE && $past(O_ARB_ACTIVE)
      && $changed(O_SEG_INDEX) |-> run == SEG_CYCLES) else $error("segment length");
   step_order_a: assert property (O_ARB_ACTIVE && $past(O_ARB_ACTIVE)
      && $changed(O_SEG_INDEX) |-> O_SEG_INDEX == $past(O_SEG_INDEX) + 3'h1) else $error("order");
   period_start_a: assert property (O_SEG_START == (O_ARB_ACTIVE
      && O_SEG_INDEX == 3'h0 && ($changed(O_SEG_INDEX) || !$past(O_ARB_ACTIVE))))
      else $error("period start");
   amp_window_a: assert property (O_AMP_VALID == (O_ARB_ACTIVE && O_SEG_INDEX < 3'h2))
      else $error("amplitude window");
   start_c: cover property (O_SEG_START);
   read_c: cover property (O_RVALID && O_RDATA != 8'h00);
   drop_c: cover property ($fell(I_ARB_MODE) && O_ARB_ACTIVE);
endmodule

bind clps_cable_loss_pulse_regs clps_cable_loss_pulse_regs_sva #(.SEG_CYCLES(SEG_CYCLES)) sva_i (
   .I_CLOCK, .I_SRST, .I_REQ, .O_RDATA, .O_RVALID, .I_EQ_SETTING, .I_ARB_MODE,
   .O_SEG_INDEX, .O_SEG_START, .O_ARB_ACTIVE, .O_AMP_VALID, .O_AMP);

// file: tb/clps_cable_loss_pulse_regs_tb_top.sv
module clps_cable_loss_pulse_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SEGC = 2;
   logic clk = 1'b0, srst = 1'b1, arb = 1'b0;
   logic [5:0] eq = 6'h00;
   logic rvalid, start, active, amp_valid;
   logic [7:0] rdata, s1, s2;
   logic [2:0] idx;
   clps_pkg::clps_req_s req;
   clps_pkg::clps_amp_s amp;
   logic [7:0] exp_q[$];
   int err_count = 0, n_tests = 0, seed = 32'h4987;
   // 200 MHz
   always #2.5 clk = ~clk;
   clps_host_model clps_host_model_i (.i_clock(clk), .o_req(req));
   clps_cable_loss_pulse_regs #(.SEG_CYCLES(SEGC)) clps_cable_loss_pulse_regs_i (
      .I_CLOCK(clk), .I_SRST(srst), .I_REQ(req), .O_RDATA(rdata), .O_RVALID(rvalid),
      .I_EQ_SETTING(eq), .I_ARB_MODE(arb), .O_SEG_INDEX(idx), .O_SEG_START(start),
      .O_ARB_ACTIVE(active), .O_AMP_VALID(amp_valid), .O_AMP(amp));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Expectation queued before the request leaves
   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      clps_host_model_i.acc(a, 1'b0, 8'h00);
   endtask
   task automatic test_done();
      // A read still waiting for its answer is a mismatch too
      chk(8'(exp_q.size()), 8'h00);
      if (err_count == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Each answer retires the oldest expectation; a spare answer is an error
   always @(posedge clk) begin
      if (rvalid === 1'b1 && exp_q.size() == 0) chk(8'h01, 8'h00);
      else if (rvalid === 1'b1) chk(rdata, exp_q.pop_front());
   end
   // Watchdog, over twenty times the expected run
   initial begin
      repeat (5000) @(posedge clk);
      err_count++;
      test_done();
   end
   initial begin
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      rd(5'h07, 8'h00);
      rd(5'h08, 8'h00);
      rd(5'h09, 8'h00);
      rd(5'h1F, 8'h00);
      // Back-to-back traffic, write to the read-only place included
      for (int i = 0; i < 20; i++) begin
         eq <= 6'($random(seed));
         s1 = 8'($random(seed));
         s2 = 8'($random(seed));
         clps_host_model_i.acc(5'h08, 1'b1, s1);
         clps_host_model_i.acc(5'h07, 1'b1, ~s1);
         clps_host_model_i.acc(5'h09, 1'b1, s2);
         rd(5'h09, s2);
         rd(5'h08, s1);
         rd(5'h07, {2'b00, eq});
      end
      clps_host_model_i.idle();
      arb <= 1'b1;
      // Second pass sees a segment one value rewritten mid-period
      for (int p = 0; p < 2; p++) begin
         @(negedge clk);
         for (int k = 0; k < 40 && start !== 1'b1; k++) @(negedge clk);
         chk({1'b0, amp}, {1'b0, s1[6:0]});
         repeat (SEGC) @(negedge clk);
         chk({4'h0, amp_valid, idx}, 8'h09);
         chk({1'b0, amp}, {1'b0, s2[6:0]});
         s1 = 8'($random(seed));
         clps_host_model_i.acc(5'h08, 1'b1, s1);
         clps_host_model_i.idle();
      end
      @(posedge clk);
      arb <= 1'b0;
      repeat (2) @(negedge clk);
      chk({active, amp}, 8'h00);
      repeat (40) begin
         @(posedge clk);
         arb <= 1'($random(seed));
      end
      @(posedge clk);
      srst <= 1'b1;
      @(posedge clk);
      srst <= 1'b0;
      rd(5'h08, 8'h00);
      rd(5'h09, 8'h00);
      clps_host_model_i.idle();
      repeat (4) @(posedge clk);
      test_done();
   end
endmodule

// file: tb/clps_host_model.sv
module clps_host_model (
   input wire logic i_clock, // Clock
   output clps_pkg::clps_req_s o_req // Request
);
   timeunit 1ns;
   timeprecision 1ps;
   initial o_req = '0;
   // One request per call, held over exactly one taking edge
   task automatic acc(input logic [4:0] a, input logic w, input logic [7:0] d);
      @(posedge i_clock);
      o_req <= '{addr: a, wr: w, rd: !w, wdata: d};
   endtask
   // Released bus shows inverted leftovers, so stale data cannot pass
   task automatic idle();
      @(posedge i_clock);
      o_req <= '{addr: ~o_req.addr, wr: 1'b0, rd: 1'b0, wdata: ~o_req.wdata};
   endtask
endmodule
